/* File: core/mtsr_pkg.sv */
// register bank constants for the timing and security control registers
// assumes a classic wishbone slave with 8-bit registers at word-aligned addresses on a 32-bit bus
package mtsr_pkg;
    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_TX_TURNAROUND_TIME = 8'h27;
    localparam logic [7:0] IDX_HALF_SYMBOL_TIMER_LOW = 8'h28;
    localparam logic [7:0] IDX_HALF_SYMBOL_TIMER_HIGH = 8'h29;
    localparam logic [7:0] IDX_SOFTWARE_RESET_CTRL = 8'h2A;
    localparam logic [7:0] IDX_SECURITY_CONTROL_A = 8'h2C;
    localparam logic [7:0] IDX_SECURITY_CONTROL_B = 8'h2D;
    localparam logic [7:0] IDX_RADIO_SETTLE_AND_SIFS = 8'h2E;
    localparam logic [7:0] IDX_RX_SECURITY_STATUS = 8'h30;
    localparam logic [7:0] IDX_INTERRUPT_FLAGS = 8'h31;
    localparam logic [7:0] IDX_LONG_IFS = 8'h21;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] RST_TURNAROUND = 4'h4;
    localparam logic [3:0] TURNAROUND_LOW_NIBBLE = 4'h8;
    localparam logic [3:0] RST_VCO_SETTLE = 4'h7;
    localparam logic [3:0] RST_SHORT_IFS = 4'h5;
    localparam logic [5:0] RST_LONG_IFS = 6'h21;
    localparam logic [2:0] SUITE_NONE = 3'h0;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SRST_PWR_BIT = 2;
    localparam int SRST_BB_BIT = 1;
    localparam int SRST_MAC_BIT = 0;
    localparam int SECA_SKIP_BIT = 7;
    localparam int SECA_GO_BIT = 6;
    localparam int SECB_DECDIS_BIT = 1;
    localparam int SECB_ENCDIS_BIT = 0;
    localparam int RXS_MIC_BIT = 6;
    localparam int RXS_BAT_BIT = 5;
    localparam int RXS_DECERR_BIT = 2;
    localparam int IRQ_HST_BIT = 5;
    localparam int IRQ_KEY_BIT = 4;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int HALF_SYMBOL_PS = 8000000;
    localparam int HALF_SYMBOL_CYCLES = HALF_SYMBOL_PS / CLK_PERIOD_PS;
    localparam logic [1:0] SOFT_RESET_CYCLES = 2'h2;
    typedef enum logic [2:0] {
        MTSR_NONE = 3'h0, MTSR_CTR = 3'h1, MTSR_CCM128 = 3'h2, MTSR_CCM64 = 3'h3,
        MTSR_CCM32 = 3'h4, MTSR_CBC128 = 3'h5, MTSR_CBC64 = 3'h6, MTSR_CBC32 = 3'h7
    } mtsr_suite_t;
endpackage : mtsr_pkg

/* File: core/mtsr_regs.sv */
// timing and security control register bank with a wishbone slave port
// assumes the cipher, radio and supply monitor drive their event inputs synchronously
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
// Operation
// - turnaround plus vco settle make twelve symbols (reset values four and seven give eleven; hardware stores what is written)
// - turnaround resets to four, never below two (hardware stores any written value, zero and one included)
// - sixteen-bit half-symbol timer, two bytes, reset zero
// - power reset bit pulses then self-clears
// - baseband reset bit pulses then self-clears
// - mac reset bit pulses then self-clears
// - decrypt skip write pulses skip command
// - decrypt go write pulses start command
// - receive suite field, eight codes, reset none
// - normal transmit suite field bits two-zero
// - beacon transmit suite field bits six-four
// - decrypt disable suppresses security interrupt
// - encrypt disable sends packets unencrypted
// - vco settle field resets to seven
// - short ifs plus vco settle make twelve
// - mic error flag sets, write one clears
// - battery flag follows supply monitor
// - decrypt error flag shows decryption error
// - reserved security control b bits read zero
// - long ifs plus vco settle make forty
// - interrupt flags clear on status read
module mtsr_regs #(
    parameter int ADDR_W = 10
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_secure_frame,
    input wire logic mic_error_evt,
    input wire logic decrypt_error_evt,
    input wire logic supply_below_threshold,
    output logic [3:0] turnaround_symbols,
    output logic [3:0] vco_settle_symbols,
    output logic [3:0] short_ifs_symbols,
    output logic [5:0] long_ifs_symbols,
    output logic [15:0] half_symbol_count,
    output logic power_mgmt_reset,
    output logic baseband_reset,
    output logic mac_core_reset,
    output logic rx_decrypt_skip,
    output logic rx_decrypt_go,
    output logic [2:0] rx_suite_sel,
    output logic [2:0] tx_normal_suite_sel,
    output logic [2:0] tx_beacon_suite_sel,
    output logic tx_encrypt_active,
    output logic [7:0] interrupt_flags
);
    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic req;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [7:0] wd;
    logic half_tick;
    logic [11:0] tick_cnt_r;
    logic [1:0] srst_cnt_r;
    logic [2:0] srst_r;
    logic decrypt_disable_r;
    logic encrypt_disable_r;
    logic mic_err_r;
    logic dec_err_r;
    logic bat_r;
    logic [7:0] rdata;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign idx = wb_adr_i[9:2];
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;
    assign wd = wb_dat_i[7:0];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // ----------------------------------------------------------------
    // interframe timing fields
    // ----------------------------------------------------------------
    // sums are software's duty; hardware stores what is written
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            turnaround_symbols <= mtsr_pkg::RST_TURNAROUND;
            vco_settle_symbols <= mtsr_pkg::RST_VCO_SETTLE;
            short_ifs_symbols <= mtsr_pkg::RST_SHORT_IFS;
            long_ifs_symbols <= mtsr_pkg::RST_LONG_IFS;
        end else if (wr) begin
            if (hit(idx, mtsr_pkg::IDX_TX_TURNAROUND_TIME)) begin
                turnaround_symbols <= wd[7:4];
            end
            if (hit(idx, mtsr_pkg::IDX_RADIO_SETTLE_AND_SIFS)) begin
                vco_settle_symbols <= wd[7:4];
                short_ifs_symbols <= wd[3:0];
            end
            if (hit(idx, mtsr_pkg::IDX_LONG_IFS)) begin
                long_ifs_symbols <= wd[7:2];
            end
        end
    end

    // ----------------------------------------------------------------
    // half-symbol timer
    // ----------------------------------------------------------------
    // counts down one per 8 us toward zero once loaded; write wins over tick
    assign half_tick = (tick_cnt_r == 12'(mtsr_pkg::HALF_SYMBOL_CYCLES - 1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_r <= 12'h000;
        end else if (half_tick) begin
            tick_cnt_r <= 12'h000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 12'h001;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            half_symbol_count <= 16'h0000;
        end else if (wr && hit(idx, mtsr_pkg::IDX_HALF_SYMBOL_TIMER_LOW)) begin
            half_symbol_count[7:0] <= wd;
        end else if (wr && hit(idx, mtsr_pkg::IDX_HALF_SYMBOL_TIMER_HIGH)) begin
            half_symbol_count[15:8] <= wd;
        end else if (half_tick && half_symbol_count != 16'h0000) begin
            half_symbol_count <= half_symbol_count - 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // soft resets
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            srst_r <= 3'h0;
            srst_cnt_r <= 2'h0;
        end else if (wr && hit(idx, mtsr_pkg::IDX_SOFTWARE_RESET_CTRL) && (|wd[2:0])) begin
            srst_r <= srst_r | wd[2:0];
            srst_cnt_r <= mtsr_pkg::SOFT_RESET_CYCLES;
        end else if (srst_cnt_r != 2'h0) begin
            srst_cnt_r <= srst_cnt_r - 2'h1;
        end else begin
            srst_r <= 3'h0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            power_mgmt_reset <= 1'b0;
            baseband_reset <= 1'b0;
            mac_core_reset <= 1'b0;
        end else begin
            power_mgmt_reset <= srst_r[mtsr_pkg::SRST_PWR_BIT];
            baseband_reset <= srst_r[mtsr_pkg::SRST_BB_BIT];
            mac_core_reset <= srst_r[mtsr_pkg::SRST_MAC_BIT];
        end
    end

    // ----------------------------------------------------------------
    // security control
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_decrypt_skip <= 1'b0;
            rx_decrypt_go <= 1'b0;
        end else begin
            rx_decrypt_skip <= wr && hit(idx, mtsr_pkg::IDX_SECURITY_CONTROL_A) && wd[7];
            rx_decrypt_go <= wr && hit(idx, mtsr_pkg::IDX_SECURITY_CONTROL_A) && wd[6];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_suite_sel <= mtsr_pkg::SUITE_NONE;
            tx_normal_suite_sel <= mtsr_pkg::SUITE_NONE;
            tx_beacon_suite_sel <= mtsr_pkg::SUITE_NONE;
            decrypt_disable_r <= 1'b0;
            encrypt_disable_r <= 1'b0;
        end else if (wr) begin
            if (hit(idx, mtsr_pkg::IDX_SECURITY_CONTROL_A)) begin
                rx_suite_sel <= wd[5:3];
                tx_normal_suite_sel <= wd[2:0];
            end
            if (hit(idx, mtsr_pkg::IDX_SECURITY_CONTROL_B)) begin
                tx_beacon_suite_sel <= wd[6:4];
                decrypt_disable_r <= wd[mtsr_pkg::SECB_DECDIS_BIT];
                encrypt_disable_r <= wd[mtsr_pkg::SECB_ENCDIS_BIT];
            end
        end
    end

    // encryption engages only when a suite is chosen and not disabled
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_encrypt_active <= 1'b0;
        end else begin
            tx_encrypt_active <= (tx_normal_suite_sel != mtsr_pkg::SUITE_NONE) && !encrypt_disable_r;
        end
    end

    // ----------------------------------------------------------------
    // receive status
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mic_err_r <= 1'b0;
        end else if (mic_error_evt) begin
            mic_err_r <= 1'b1;
        end else if (wr && hit(idx, mtsr_pkg::IDX_RX_SECURITY_STATUS) && wd[mtsr_pkg::RXS_MIC_BIT]) begin
            mic_err_r <= 1'b0;
        end
    end

    // decryption error is sticky until the next decrypt launch
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dec_err_r <= 1'b0;
        end else if (decrypt_error_evt) begin
            dec_err_r <= 1'b1;
        end else if (rx_decrypt_go) begin
            dec_err_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bat_r <= 1'b0;
        end else begin
            bat_r <= supply_below_threshold;
        end
    end

    // ----------------------------------------------------------------
    // interrupt flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_flags <= 8'h00;
        end else begin
            if (rd && hit(idx, mtsr_pkg::IDX_INTERRUPT_FLAGS)) begin
                interrupt_flags <= 8'h00;
            end
            if (rx_secure_frame && !decrypt_disable_r) begin
                interrupt_flags[mtsr_pkg::IRQ_KEY_BIT] <= 1'b1;
            end
            if (half_tick && half_symbol_count == 16'h0001) begin
                interrupt_flags[mtsr_pkg::IRQ_HST_BIT] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        case (idx)
            mtsr_pkg::IDX_TX_TURNAROUND_TIME: rdata = {turnaround_symbols, mtsr_pkg::TURNAROUND_LOW_NIBBLE};
            mtsr_pkg::IDX_HALF_SYMBOL_TIMER_LOW: rdata = half_symbol_count[7:0];
            mtsr_pkg::IDX_HALF_SYMBOL_TIMER_HIGH: rdata = half_symbol_count[15:8];
            mtsr_pkg::IDX_SOFTWARE_RESET_CTRL: rdata = {5'h00, srst_r};
            mtsr_pkg::IDX_SECURITY_CONTROL_A: rdata = {2'h0, rx_suite_sel, tx_normal_suite_sel};
            mtsr_pkg::IDX_SECURITY_CONTROL_B: rdata = {1'b0, tx_beacon_suite_sel, 2'h0, decrypt_disable_r,
                encrypt_disable_r};
            mtsr_pkg::IDX_RADIO_SETTLE_AND_SIFS: rdata = {vco_settle_symbols, short_ifs_symbols};
            mtsr_pkg::IDX_RX_SECURITY_STATUS: rdata = {1'b0, mic_err_r, bat_r, 2'h0, dec_err_r, 2'h0};
            mtsr_pkg::IDX_INTERRUPT_FLAGS: rdata = interrupt_flags;
            mtsr_pkg::IDX_LONG_IFS: rdata = {long_ifs_symbols, 2'h0};
            default: rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= {24'h00_0000, rd ? rdata : 8'h00};
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_srst_write;
        wr && hit(idx, mtsr_pkg::IDX_SOFTWARE_RESET_CTRL) && wd[0];
    endsequence
    property p_mac_reset_pulse;
        @(posedge clk) disable iff (!reset_n) s_srst_write |=> ##1 mac_core_reset [*3] ##1 !mac_core_reset;
    endproperty
    a_mac_reset_pulse: assert property (p_mac_reset_pulse) else $error("mac reset not pulsed");
    property p_srst_clears;
        @(posedge clk) disable iff (!reset_n) s_srst_write |=> ##3 srst_r == 3'h0;
    endproperty
    a_srst_clears: assert property (p_srst_clears) else $error("soft reset bit not cleared");
    property p_go_pulse;
        @(posedge clk) disable iff (!reset_n) rx_decrypt_go |=> !rx_decrypt_go || $past(wr);
    endproperty
    a_go_pulse: assert property (p_go_pulse) else $error("decrypt go not a pulse");
    property p_mic_hold;
        @(posedge clk) disable iff (!reset_n) mic_error_evt |=> mic_err_r;
    endproperty
    a_mic_hold: assert property (p_mic_hold) else $error("mic flag lost");
    property p_bat_follow;
        @(posedge clk) disable iff (!reset_n) ##1 bat_r == $past(supply_below_threshold);
    endproperty
    a_bat_follow: assert property (p_bat_follow) else $error("battery flag wrong");
    property p_key_masked;
        @(posedge clk) disable iff (!reset_n)
            decrypt_disable_r && !interrupt_flags[4] ##1 1'b1 |-> !interrupt_flags[4] || !$past(decrypt_disable_r);
    endproperty
    a_key_masked: assert property (p_key_masked) else $error("key interrupt while disabled");
    property p_enc_off;
        @(posedge clk) disable iff (!reset_n) encrypt_disable_r |=> !tx_encrypt_active;
    endproperty
    a_enc_off: assert property (p_enc_off) else $error("encrypting while disabled");
    property p_irq_clear;
        @(posedge clk) disable iff (!reset_n)
            rd && hit(idx, mtsr_pkg::IDX_INTERRUPT_FLAGS) && !rx_secure_frame && !half_tick |=> interrupt_flags == 8'h00;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("flags not cleared on read");
    property p_ack_one;
        @(posedge clk) disable iff (!reset_n) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than a cycle");
    sequence s_seca_write;
        wr && hit(idx, mtsr_pkg::IDX_SECURITY_CONTROL_A);
    endsequence
    property p_skip_pulse;
        @(posedge clk) disable iff (!reset_n) s_seca_write ##0 wd[mtsr_pkg::SECA_SKIP_BIT] |=> rx_decrypt_skip;
    endproperty
    a_skip_pulse: assert property (p_skip_pulse) else $error("decrypt skip not pulsed");
    property p_go_start;
        @(posedge clk) disable iff (!reset_n) s_seca_write ##0 wd[mtsr_pkg::SECA_GO_BIT] |=> rx_decrypt_go;
    endproperty
    a_go_start: assert property (p_go_start) else $error("decrypt go not pulsed");
    property p_seca_cmd_zero;
        @(posedge clk) disable iff (!reset_n)
            rd && hit(idx, mtsr_pkg::IDX_SECURITY_CONTROL_A) |=> wb_dat_o[7:6] == 2'h0;
    endproperty
    a_seca_cmd_zero: assert property (p_seca_cmd_zero) else $error("command bits read nonzero");
    property p_secb_reserved;
        @(posedge clk) disable iff (!reset_n)
            rd && hit(idx, mtsr_pkg::IDX_SECURITY_CONTROL_B) |=> !wb_dat_o[7] && wb_dat_o[3:2] == 2'h0;
    endproperty
    a_secb_reserved: assert property (p_secb_reserved) else $error("reserved bits read nonzero");
    property p_turn_nibble;
        @(posedge clk) disable iff (!reset_n)
            rd && hit(idx, mtsr_pkg::IDX_TX_TURNAROUND_TIME) |=> wb_dat_o[3:0] == mtsr_pkg::TURNAROUND_LOW_NIBBLE;
    endproperty
    a_turn_nibble: assert property (p_turn_nibble) else $error("turnaround low nibble wrong");
    property p_timer_low_write;
        @(posedge clk) disable iff (!reset_n)
            wr && hit(idx, mtsr_pkg::IDX_HALF_SYMBOL_TIMER_LOW) |=> half_symbol_count[7:0] == $past(wd);
    endproperty
    a_timer_low_write: assert property (p_timer_low_write) else $error("timer low byte not written");
    property p_dec_err_set;
        @(posedge clk) disable iff (!reset_n) decrypt_error_evt |=> dec_err_r;
    endproperty
    a_dec_err_set: assert property (p_dec_err_set) else $error("decrypt error flag lost");
endmodule : mtsr_regs

/* File: test/mtsr_host.sv */
// host model: classic wishbone master that programs the register bank
// assumes a slave that acks within a few cycles; a missing ack raises hung
`timescale 1ns/1ps
module mtsr_host (
    input wire logic clk,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    output logic wb_cyc_i,
    output logic wb_stb_i,
    output logic wb_we_i,
    output logic [9:0] wb_adr_i,
    output logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_i,
    output logic hung
);
    initial begin
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 10'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        hung = 1'b0;
    end
    // ------------------------------------------------------------
    // single classic cycle, held until ack is sampled high
    // ------------------------------------------------------------
    task automatic xfer(input logic we, input logic [7:0] idx, input logic [3:0] sel, input logic [7:0] wd,
                        output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= {24'h00_0000, wd};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        rd = wb_dat_o;
        if (wb_ack_o !== 1'b1) hung <= 1'b1;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        // released lines must not keep looking valid
        wb_adr_i <= ~wb_adr_i;
        wb_dat_i <= ~wb_dat_i;
        #1;
    endtask : xfer
endmodule : mtsr_host

/* File: test/mac_timing_security_ctrl_regs_tb.sv */
// self-checking bench for the timing and security register bank
// assumes the bank is reached only through the host model's bus cycles
`timescale 1ns/1ps
module mac_timing_security_ctrl_regs_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, hung;
    logic [9:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic rx_secure_frame = 1'b0, mic_error_evt = 1'b0, decrypt_error_evt = 1'b0, supply_below_threshold = 1'b0;
    logic [3:0] turnaround_symbols, vco_settle_symbols, short_ifs_symbols;
    logic [5:0] long_ifs_symbols;
    logic [15:0] half_symbol_count;
    logic power_mgmt_reset, baseband_reset, mac_core_reset, rx_decrypt_skip, rx_decrypt_go, tx_encrypt_active;
    logic [2:0] rx_suite_sel, tx_normal_suite_sel, tx_beacon_suite_sel;
    logic [7:0] interrupt_flags;
    int n_errors = 0;
    int n_compared = 0;
    int n_go = 0;
    int n_skip = 0;

    always #2.5 clk = ~clk;

    mtsr_regs u_dut (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .rx_secure_frame, .mic_error_evt, .decrypt_error_evt, .supply_below_threshold,
        .turnaround_symbols, .vco_settle_symbols, .short_ifs_symbols, .long_ifs_symbols, .half_symbol_count,
        .power_mgmt_reset, .baseband_reset, .mac_core_reset, .rx_decrypt_skip, .rx_decrypt_go, .rx_suite_sel,
        .tx_normal_suite_sel, .tx_beacon_suite_sel, .tx_encrypt_active, .interrupt_flags);
    mtsr_host u_host (.clk, .wb_dat_o, .wb_ack_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .hung);

    always @(posedge clk) begin
        if (rx_decrypt_go === 1'b1) n_go++;
        if (rx_decrypt_skip === 1'b1) n_skip++;
        if (hung === 1'b1) begin
            n_errors++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // compares and bus helpers
    // ------------------------------------------------------------
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: port value %h, expected %h", $time, got, exp);
        end
    endtask : chk_out
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] sel = 4'hF);
        u_host.xfer(1'b1, idx, sel, d, rd);
    endtask : wr
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        u_host.xfer(1'b0, idx, 4'hF, 8'h00, rd);
        chk_reg(rd, {24'h00_0000, exp});
    endtask : rd_chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic give_verdict;
        if (n_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic sc_reset_values;
        chk_out(16'(turnaround_symbols), 16'h0004);
        chk_out(16'(vco_settle_symbols), 16'h0007);
        chk_out(16'(short_ifs_symbols), 16'h0005);
        chk_out(16'(long_ifs_symbols), 16'h0021);
        rd_chk(8'h27, 8'h48);
        rd_chk(8'h2E, 8'h75);
        rd_chk(8'h28, 8'h00);
        rd_chk(8'h29, 8'h00);
        rd_chk(8'h2C, 8'h00);
        rd_chk(8'h2D, 8'h00);
        rd_chk(8'h30, 8'h00);
        rd_chk(8'h2B, 8'h00);
    endtask : sc_reset_values
    task automatic sc_timing;
        wr(8'h27, 8'h38);
        wr(8'h2E, 8'h93);
        wr(8'h21, 8'h7C);
        chk_out(16'(turnaround_symbols), 16'h0003);
        chk_out(16'(vco_settle_symbols), 16'h0009);
        chk_out(16'(short_ifs_symbols), 16'h0003);
        chk_out(16'(long_ifs_symbols), 16'h001F);
        rd_chk(8'h27, 8'h38);
        rd_chk(8'h2E, 8'h93);
    endtask : sc_timing
    task automatic sc_soft_reset;
        logic [2:0] bit_v;
        int n;
        for (int i = 0; i < 3; i++) begin
            bit_v = 3'h1 << i;
            n = 0;
            wr(8'h2A, {5'h00, bit_v});
            // the pulse starts on the ack edge, so sample before each step
            for (int c = 0; c < 8; c++) begin
                if ({power_mgmt_reset, baseband_reset, mac_core_reset} === bit_v) n++;
                tick(1);
            end
            chk_out(16'(n), 16'h0003);
            rd_chk(8'h2A, 8'h00);
        end
    endtask : sc_soft_reset
    task automatic sc_sec_a;
        for (int s = 0; s < 8; s++) begin
            wr(8'h2C, {2'b00, 3'(s), 3'(s)});
            rd_chk(8'h2C, {2'b00, 3'(s), 3'(s)});
            chk_out(16'(rx_suite_sel), 16'(s));
            chk_out(16'(tx_normal_suite_sel), 16'(s));
        end
        wr(8'h2C, 8'h7F);
        rd_chk(8'h2C, 8'h3F);
        wr(8'h2C, 8'hBF);
        tick(3);
        chk_out(16'(n_go), 16'h0001);
        chk_out(16'(n_skip), 16'h0001);
    endtask : sc_sec_a
    task automatic sc_sec_b;
        wr(8'h2D, 8'hFF);
        rd_chk(8'h2D, 8'h73);
        chk_out(16'(tx_beacon_suite_sel), 16'h0007);
        chk_out(16'(tx_encrypt_active), 16'h0000);
        // a write without the low byte lane must leave the register alone
        wr(8'h2D, 8'h00, 4'hE);
        rd_chk(8'h2D, 8'h73);
        @(posedge clk) rx_secure_frame <= 1'b1;
        @(posedge clk) rx_secure_frame <= 1'b0;
        tick(2);
        chk_out(16'(interrupt_flags), 16'h0000);
        wr(8'h2D, 8'h00);
        chk_out(16'(tx_encrypt_active), 16'h0001);
        @(posedge clk) rx_secure_frame <= 1'b1;
        @(posedge clk) rx_secure_frame <= 1'b0;
        tick(2);
        chk_out(16'(interrupt_flags), 16'h0010);
        rd_chk(8'h31, 8'h10);
        chk_out(16'(interrupt_flags), 16'h0000);
    endtask : sc_sec_b
    task automatic sc_status;
        @(posedge clk) supply_below_threshold <= 1'b1;
        mic_error_evt <= 1'b1;
        decrypt_error_evt <= 1'b1;
        @(posedge clk) mic_error_evt <= 1'b0;
        decrypt_error_evt <= 1'b0;
        rd_chk(8'h30, 8'h64);
        wr(8'h30, 8'h40);
        @(posedge clk) supply_below_threshold <= 1'b0;
        rd_chk(8'h30, 8'h04);
    endtask : sc_status
    task automatic sc_timer;
        int n;
        wr(8'h28, 8'h80);
        wr(8'h29, 8'hA5);
        rd_chk(8'h29, 8'hA5);
        wr(8'h29, 8'h00);
        wr(8'h28, 8'h02);
        n = 0;
        while (half_symbol_count !== 16'h0000 && n < 4000) begin
            tick(1);
            n++;
        end
        // two ticks 1600 cycles apart; the first may fall on the edge after the write
        chk_out(16'(n >= 1600 && n < 3200), 16'h0001);
        tick(2);
        chk_out(16'(interrupt_flags), 16'h0020);
        rd_chk(8'h31, 8'h20);
        chk_out(16'(interrupt_flags), 16'h0000);
    endtask : sc_timer

    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        tick(1);
        sc_reset_values();
        sc_timing();
        sc_soft_reset();
        sc_sec_a();
        sc_sec_b();
        sc_status();
        sc_timer();
        give_verdict();
    end
endmodule : mac_timing_security_ctrl_regs_tb
